// ### fcg_pkg.sv
/*
  constants shared by the fast core gpio front end and its bench.
  assumes one core clock domain; pins are asynchronous to it.
*/
package fcg_pkg;
  // widths of the pin groups and core words
  localparam int GPIO_W   = 20;  // dedicated input and output pins
  localparam int CAP_W    = 16;  // parallel capture word
  localparam int SHIFT_W  = 28;  // serial shift register
  localparam int WORD_W   = 32;  // core register width
  localparam int EVT_W    = 2;   // pending and released system events
  localparam int EVT_LSB  = 30;  // event field position in status word
  localparam int DIV_W    = 8;   // width of each shift clock divider
  localparam int CNT_W    = 5;   // bit counter width, holds 0 to 28

  // mode select encodings
  localparam logic [1:0] MODE_DIRECT   = 2'h0;
  localparam logic [1:0] MODE_PARALLEL = 2'h1;
  localparam logic [1:0] MODE_SHIFT    = 2'h2;
  localparam logic [1:0] MODE_ETH      = 2'h3;

  // reset values
  localparam logic [GPIO_W-1:0]  GPO_RST   = 20'h00000;
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 28'h0000000;
  localparam logic [CNT_W-1:0]   CNT_ZERO  = 5'h00;
  localparam logic [CNT_W-1:0]   CNT_FULL  = 5'h1c;  // 28 bits
  localparam logic [DIV_W-1:0]   DIV_ZERO  = 8'h00;

  // shift engine states
  typedef enum logic [1:0] {
    FCG_IDLE,
    FCG_RUN
  } fcg_shift_state_t;
endpackage

// ### fcg_buf2.sv
/*
  two-entry buffer with valid and ready on both sides.
  assumes a single clock; all outputs come from flip-flops.
*/
`timescale 1ns/10ps
module fcg_buf2 #(
  parameter int W = 28
) (
  input  wire logic         mclk_i,    // core clock
  input  wire logic         reset_i,   // async reset, active high
  input  wire logic         in_valid_i, // word offered
  input  wire logic [W-1:0] in_data_i,  // word
  output logic              in_ready_o, // room for a word
  output logic              out_valid_o, // word held
  output logic [W-1:0]      out_data_o,  // head word
  input  wire logic         out_ready_i  // consumer takes word
);
  logic         spare_valid;
  logic [W-1:0] spare_data;
  wire          push = in_valid_i && in_ready_o;
  wire          pop_free = !out_valid_o || out_ready_i;

  // ready is registered; the spare slot absorbs the word in flight
  assign in_ready_o = !spare_valid;

  // head refills from spare first so order is kept
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      spare_valid <= 1'b0;
      spare_data  <= '0;
    end
    else if (pop_free)
    begin
      out_valid_o <= spare_valid || push;
      out_data_o  <= spare_valid ? spare_data : in_data_i;
      spare_valid <= 1'b0;
    end
    else if (push)
    begin
      spare_valid <= 1'b1;
      spare_data  <= in_data_i;
    end
  end
endmodule

// ### fcg_gpio.sv
/*
  fast core gpio front end: direct, parallel capture and serial shift
  modes between a core register file and pins; the ethernet mode code drives nothing.
  assumes the core strobes writes for one cycle and holds mode_i stable.
*/
`timescale 1ns/10ps
module fcg_gpio #(
  parameter int GW = fcg_pkg::GPIO_W,
  parameter int SW = fcg_pkg::SHIFT_W
) (
  input  wire logic                         mclk_i,     // core clock
  input  wire logic                         reset_i,    // async reset
  input  wire logic [1:0]                   mode_i,     // mode select
  input  wire logic                         cap_fall_i, // capture on fall
  input  wire logic [fcg_pkg::DIV_W-1:0]    div1_i,     // first divider
  input  wire logic [fcg_pkg::DIV_W-1:0]    div2_i,     // second divider
  input  wire logic                         out_wr_i,   // output reg write
  input  wire logic [fcg_pkg::WORD_W-1:0]   out_wdata_i, // output reg data
  input  wire logic                         stat_wr_i,  // status reg write
  input  wire logic [fcg_pkg::EVT_W-1:0]    stat_wdata_i, // events to raise
  input  wire logic [fcg_pkg::EVT_W-1:0]    evt_pend_i, // events for core
  output logic [fcg_pkg::WORD_W-1:0]        stat_rdata_o, // status word
  output logic [fcg_pkg::EVT_W-1:0]         evt_release_o, // event pulses
  input  wire logic [GW-1:0]                gpi_i,      // input pins
  output logic [GW-1:0]                     gpo_o,      // output pins
  input  wire logic                         ext_cap_clk_i, // capture clock
  input  wire logic                         ser_in_i,   // serial/par data 0
  output logic                              ser_out_o,  // serial output
  output logic                              shift_clk_o, // shift clock out
  output logic                              word_valid_o, // captured word
  output logic [SW-1:0]                     word_data_o, // captured data
  input  wire logic                         word_ready_i, // consumer ready
  output logic                              busy_o      // shift-out active
);
  // pin synchronisers: stage 1 feeds only stage 2
  logic [GW-1:0] gpi_s1, gpi_s2;
  logic          cap_s1, cap_s2, cap_s3;
  logic          din_s1, din_s2;

  // mode decode, only one active at a time
  wire is_direct = (mode_i == fcg_pkg::MODE_DIRECT);
  wire is_par    = (mode_i == fcg_pkg::MODE_PARALLEL);
  wire is_shift  = (mode_i == fcg_pkg::MODE_SHIFT);

  // parallel data pin 0 is the serial input line; 15 pins read gpi
  wire [fcg_pkg::CAP_W-1:0] par_word =
    {gpi_s2[fcg_pkg::CAP_W-1:1], din_s2};
  wire cap_rise = cap_s2 && !cap_s3;
  wire cap_fall = !cap_s2 && cap_s3;
  wire cap_edge = is_par && (cap_fall_i ? cap_fall : cap_rise);

  // shift clock from two cascaded dividers
  logic [fcg_pkg::DIV_W-1:0] div1_cnt, div2_cnt;
  wire div1_wrap = (div1_cnt == div1_i);
  wire div_tick  = is_shift && div1_wrap && (div2_cnt == div2_i);
  wire sh_rise   = div_tick && !shift_clk_o;  // shift clock goes high

  // shift-out engine
  fcg_pkg::fcg_shift_state_t state;
  logic [SW-1:0]             out_sr;
  logic [fcg_pkg::CNT_W-1:0] out_cnt;
  wire out_load = is_shift && out_wr_i && (state == fcg_pkg::FCG_IDLE);
  wire out_step = (state == fcg_pkg::FCG_RUN) && sh_rise;

  // shift-in engine
  logic [SW-1:0]             in_sr;
  logic [fcg_pkg::CNT_W-1:0] in_cnt;
  wire in_full = (in_cnt == fcg_pkg::CNT_FULL);
  // sampling waits while a full word has nowhere to go
  wire in_step = sh_rise && !in_full;
  wire [SW-1:0] in_bit = {{(SW-1){1'b0}}, din_s2} << in_cnt;

  // buffer feed: full shift word or captured parallel word
  logic buf_rdy;
  wire  push_sh  = is_shift && in_full;
  wire  buf_vld  = push_sh || cap_edge;
  wire [SW-1:0] buf_din = push_sh ? in_sr :
    {{(SW-fcg_pkg::CAP_W){1'b0}}, par_word};
  wire  in_taken = push_sh && buf_rdy;

  // status word: pin or shift data below, events on top
  wire [SW-1:0] stat_low = is_shift ? in_sr :
    {{(SW-GW){1'b0}}, gpi_s2};
  wire [fcg_pkg::WORD_W-1:0] next_stat =
    {evt_pend_i, {(fcg_pkg::EVT_LSB-SW){1'b0}}, stat_low};

  // two flops on every pin before use
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      gpi_s1 <= '0;
      gpi_s2 <= '0;
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cap_s3 <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end
    else
    begin
      gpi_s1 <= gpi_i;
      gpi_s2 <= gpi_s1;
      cap_s1 <= ext_cap_clk_i;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
      din_s1 <= ser_in_i;
      din_s2 <= din_s1;
    end
  end

  // core registers: status read path, event release, output pins
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stat_rdata_o  <= '0;
      evt_release_o <= '0;
      gpo_o         <= fcg_pkg::GPO_RST;
    end
    else
    begin
      stat_rdata_o  <= next_stat;
      evt_release_o <= stat_wr_i ? stat_wdata_i : '0;
      if (out_wr_i && is_direct)
        gpo_o <= out_wdata_i[GW-1:0];
    end
  end

  // cascaded dividers; the toggle halves the rate once more
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      div1_cnt    <= fcg_pkg::DIV_ZERO;
      div2_cnt    <= fcg_pkg::DIV_ZERO;
      shift_clk_o <= 1'b0;
    end
    else if (!is_shift)
    begin
      div1_cnt    <= fcg_pkg::DIV_ZERO;
      div2_cnt    <= fcg_pkg::DIV_ZERO;
      shift_clk_o <= 1'b0;
    end
    else
    begin
      div1_cnt <= div1_wrap ? fcg_pkg::DIV_ZERO :
                  div1_cnt + 1'b1;
      if (div1_wrap)
        div2_cnt <= div_tick ? fcg_pkg::DIV_ZERO :
                    div2_cnt + 1'b1;
      if (div_tick)
        shift_clk_o <= !shift_clk_o;
    end
  end

  // shift-out: lsb first, one bit per rising shift clock
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state     <= fcg_pkg::FCG_IDLE;
      out_sr    <= fcg_pkg::SHIFT_RST;
      out_cnt   <= fcg_pkg::CNT_ZERO;
      ser_out_o <= 1'b0;
      busy_o    <= 1'b0;
    end
    else
    begin
      case (state)
        fcg_pkg::FCG_IDLE:
        begin
          if (out_load)
          begin
            out_sr  <= out_wdata_i[SW-1:0];
            out_cnt <= fcg_pkg::CNT_FULL;
            busy_o  <= 1'b1;
            state   <= fcg_pkg::FCG_RUN;
          end
        end
        fcg_pkg::FCG_RUN:
        begin
          if (!is_shift)
          begin
            busy_o <= 1'b0;
            state  <= fcg_pkg::FCG_IDLE;
          end
          else if (out_step)
          begin
            ser_out_o <= out_sr[0];
            out_sr    <= out_sr >> 1;
            out_cnt   <= out_cnt - 1'b1;
            if (out_cnt == 5'h01)
            begin
              busy_o <= 1'b0;
              state  <= fcg_pkg::FCG_IDLE;
            end
          end
        end
        default:
          state <= fcg_pkg::FCG_IDLE;
      endcase
    end
  end

  // shift-in: fill from bit 0; hand over the word once all 28 are in
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      in_sr  <= fcg_pkg::SHIFT_RST;
      in_cnt <= fcg_pkg::CNT_ZERO;
    end
    else if (!is_shift || in_taken)
    begin
      in_sr  <= fcg_pkg::SHIFT_RST;
      in_cnt <= fcg_pkg::CNT_ZERO;
    end
    else if (in_step)
    begin
      in_sr  <= in_sr | in_bit;
      in_cnt <= in_cnt + 1'b1;
    end
  end

  // a stalled consumer holds the shift-in word; parallel words overrun
  fcg_buf2 #(
    .W (SW)
  ) u_buf (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .in_valid_i  (buf_vld),
    .in_data_i   (buf_din),
    .in_ready_o  (buf_rdy),
    .out_valid_o (word_valid_o),
    .out_data_o  (word_data_o),
    .out_ready_i (word_ready_i)
  );

  // checks
  direct_out_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    out_wr_i && is_direct |=> gpo_o == $past(out_wdata_i[GW-1:0]))
    else $error("output pins missed write");
  direct_in_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    is_direct |-> ##3 (!is_direct ||
      stat_rdata_o[GW-1:0] == $past(gpi_i, 3)))
    else $error("status does not show input pins");
  status_evt_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    ##1 stat_rdata_o[fcg_pkg::WORD_W-1 -: fcg_pkg::EVT_W] ==
      $past(evt_pend_i))
    else $error("status lost pending events");
  evt_pulse_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    stat_wr_i |=> evt_release_o == $past(stat_wdata_i) ##1
      ($past(stat_wr_i) || evt_release_o == '0))
    else $error("event release wrong");
  rd_latency_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    ##1 stat_rdata_o == $past(next_stat))
    else $error("status read not single cycle");
  cap_edge_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    cap_edge |-> (cap_fall_i ? $fell(cap_s2) : $rose(cap_s2)))
    else $error("capture on wrong edge");
  sout_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    out_step |=> ser_out_o == $past(out_sr[0]))
    else $error("serial output bit wrong");
  sout_rise_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $changed(ser_out_o) |-> $rose(shift_clk_o))
    else $error("serial output moved off rising edge");
  sin_fill_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    in_step && !in_taken && is_shift |=> in_sr[$past(in_cnt)] ==
      $past(din_s2))
    else $error("shift-in bit placed wrong");
  sin_cap_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    in_cnt <= fcg_pkg::CNT_FULL)
    else $error("shift-in overflowed");
  one_mode_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $onehot0({is_direct, is_par, is_shift}))
    else $error("more than one mode active");
  mode_gpo_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    !is_direct |=> $stable(gpo_o))
    else $error("output pins moved outside direct mode");

  cov_direct: cover property (@(posedge mclk_i) out_wr_i && is_direct);
  cov_cap: cover property (@(posedge mclk_i) cap_edge && cap_fall_i);
  cov_sout: cover property (@(posedge mclk_i) out_step && out_cnt == 5'h01);
  cov_sin: cover property (@(posedge mclk_i) in_taken);
endmodule

// ### fcg_far_model.sv
/*
  board on the serial pins: feeds a word to the shift-in line and
  collects what the shift-out line sends.
  assumes the shift clock idles low between transfers.
*/
`timescale 1ns/10ps
module fcg_far_model (
  input  wire logic        mclk_i,      // core clock
  input  wire logic        start_i,     // shift-out load seen
  input  wire logic        shift_clk_i, // generated shift clock
  input  wire logic        ser_out_i,   // serial line from device
  input  wire logic [27:0] tx_word_i,   // word to send in
  output logic             ser_in_o,    // serial line to device
  output logic [27:0]      rx_word_o,   // word collected
  output logic [5:0]       rx_count_o,  // bits collected
  output logic [7:0]       gap_o        // clocks between rises
);
  logic       clk_q = 1'b0;
  logic [4:0] idx   = 5'h00;
  logic [7:0] cnt   = 8'h00;

  // next bit changes just after a rise, so it stands a full period
  assign ser_in_o = tx_word_i[idx];

  // a rise is seen one core clock after the edge that made it
  always @(posedge mclk_i)
  begin
    clk_q <= shift_clk_i;
    cnt   <= cnt + 8'h01;
    if (start_i)
    begin
      idx        <= 5'h00;
      rx_count_o <= 6'h00;
    end
    else if (shift_clk_i && !clk_q)
    begin
      rx_word_o  <= {ser_out_i, rx_word_o[27:1]};
      rx_count_o <= rx_count_o + 6'h01;
      idx        <= (idx == 5'h1b) ? 5'h00 : idx + 5'h01;
      gap_o      <= cnt;
      cnt        <= 8'h01;
    end
  end
endmodule

// ### fcg_gpio_bench.sv
/*
  self-checking bench for the fast core gpio front end.
  assumes fcg_far_model stands on the serial pins.
*/
`timescale 1ns/10ps
module fcg_gpio_bench;
  logic        mclk_i = 1'b0, reset_i = 1'b1;
  logic [1:0]  mode = 2'h0, stat_wdata = 2'h0, evt_pend = 2'h0, evt_rel;
  logic        cap_fall = 1'b0, out_wr = 1'b0, stat_wr = 1'b0;
  logic [7:0]  div1 = 8'h00, div2 = 8'h00, gap;
  logic [31:0] out_wdata = 32'h0, stat_rdata;
  logic [19:0] dedicated_input_pins = 20'h0, gpo, keep;
  logic        cap_clk = 1'b0, ser_in, ser_out, shift_clk, busy;
  logic        word_valid, word_ready = 1'b0;
  logic [27:0] word_data, tx = 28'h0, rx;
  logic [15:0] a, b, pw [3];
  logic [5:0]  rx_count;
  integer      seed = 32'hfa41;
  int          bad_count = 0, compares = 0, cyc = 0, i, j;

  fcg_gpio u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .mode_i(mode),
    .cap_fall_i(cap_fall), .div1_i(div1), .div2_i(div2),
    .out_wr_i(out_wr), .out_wdata_i(out_wdata), .stat_wr_i(stat_wr),
    .stat_wdata_i(stat_wdata), .evt_pend_i(evt_pend),
    .stat_rdata_o(stat_rdata), .evt_release_o(evt_rel), .gpi_i(dedicated_input_pins),
    .gpo_o(gpo), .ext_cap_clk_i(cap_clk), .ser_in_i(ser_in),
    .ser_out_o(ser_out), .shift_clk_o(shift_clk),
    .word_valid_o(word_valid), .word_data_o(word_data),
    .word_ready_i(word_ready), .busy_o(busy));

  fcg_far_model u_far (.mclk_i(mclk_i),
    .start_i(out_wr && mode == fcg_pkg::MODE_SHIFT),
    .shift_clk_i(shift_clk), .ser_out_i(ser_out), .tx_word_i(tx),
    .ser_in_o(ser_in), .rx_word_o(rx), .rx_count_o(rx_count), .gap_o(gap));

  always #10 mclk_i = ~mclk_i;

  // cut a hang short; the whole run needs well under 3000 clocks
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end

  // inputs always move 1 ns after the rising edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // expected status word: events on top, pin levels below
  function automatic logic [31:0] stat_exp(input logic [1:0]  e,
                                           input logic [19:0] p);
    return {e, 10'h0, p};
  endfunction

  // expected shift clock period in core clocks, two dividers in cascade
  function automatic int period_exp(input logic [7:0] d1,
                                    input logic [7:0] d2);
    return 2 * (d1 + 1) * (d2 + 1);
  endfunction

  task automatic write_out(input logic [31:0] d);
    out_wdata = d;
    out_wr = 1'b1;
    tick();
    out_wr = 1'b0;
  endtask

  // bit 0 of a parallel word rides on the serial input line
  task automatic set_par(input logic [15:0] d);
    dedicated_input_pins[15:1] = d[15:1];
    tx[0] = d[0];
    tick(3);
  endtask

  task automatic cap_edge(input logic lvl);
    cap_clk = lvl;
    tick(6);
  endtask

  task automatic pop(input logic [27:0] exp);
    j = 0;
    while (word_valid !== 1'b1 && j < 100)
    begin
      tick();
      j++;
    end
    check("word", {3'h0, word_valid, word_data}, {4'h1, exp});
    // ready is held for one edge, then an idle edge before the next take
    word_ready = 1'b1;
    tick();
    word_ready = 1'b0;
    tick();
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    tick(20);
    reset_i = 1'b0;
    tick();
    check("idle", {7'h0, busy, word_valid, shift_clk, evt_rel, gpo}, 0);
    // direct mode: output register to pins, pins to status word
    for (i = 0; i < 8; i++)
    begin
      dedicated_input_pins = 20'($random(seed));
      evt_pend = 2'($random(seed));
      write_out($random(seed));
      check("gpo", {12'h0, gpo}, {12'h0, out_wdata[19:0]});
      tick(3);
      check("status", stat_rdata, stat_exp(evt_pend, dedicated_input_pins));
    end
    // every event code is released as a single pulse
    for (i = 0; i < 4; i++)
    begin
      stat_wr = 1'b1;
      stat_wdata = i[1:0];
      tick();
      stat_wr = 1'b0;
      check("release", {30'h0, evt_rel}, 32'(i));
      tick();
      check("release end", {30'h0, evt_rel}, 0);
      check("pins kept", stat_rdata, stat_exp(evt_pend, dedicated_input_pins));
    end
    // parallel and ethernet modes leave the output pins alone
    keep = gpo;
    for (i = 1; i < 4; i += 2)
    begin
      mode = i[1:0];
      write_out(~out_wdata);
      check("gpo held", {12'h0, gpo}, {12'h0, keep});
      tick();
    end
    // parallel capture: only the chosen edge latches a word
    mode = fcg_pkg::MODE_PARALLEL;
    for (i = 0; i < 2; i++)
    begin
      cap_fall = i[0];
      a = 16'($random(seed));
      b = 16'($random(seed));
      set_par(a);
      cap_edge(1'b1);
      set_par(b);
      cap_edge(1'b0);
      pop({12'h0, i ? b : a});
      check("one word", {31'h0, word_valid}, 0);
    end
    // stalled consumer: two words kept, a third overruns
    word_ready = 1'b0;
    for (i = 0; i < 3; i++)
    begin
      pw[i] = 16'($random(seed));
      set_par(pw[i]);
      cap_edge(1'b1);
      cap_edge(1'b0);
    end
    pop({12'h0, pw[0]});
    pop({12'h0, pw[1]});
    tick(2);
    check("drained", {31'h0, word_valid}, 0);
    // serial shift out and in at two divider settings
    mode = fcg_pkg::MODE_DIRECT;
    for (i = 0; i < 2; i++)
    begin
      word_ready = 1'b0;
      div1 = i ? 8'h02 : 8'h00;
      div2 = i ? 8'h01 : 8'h03;
      tx = 28'($random(seed));
      tick(2);
      mode = fcg_pkg::MODE_SHIFT;
      write_out($random(seed));
      tick();
      check("busy", {31'h0, busy}, 1);
      j = 0;
      while (busy !== 1'b0 && j < 2000)
      begin
        tick();
        j++;
      end
      tick(2);
      check("sent", {4'h0, rx}, {4'h0, out_wdata[27:0]});
      check("bits", {26'h0, rx_count}, 28);
      check("period", {24'h0, gap}, period_exp(div1, div2));
      pop(tx);
      mode = fcg_pkg::MODE_DIRECT;
      tick(2);
      check("clk low", {31'h0, shift_clk}, 0);
    end
    finish_test();
  end
endmodule
